// *** logic/swtd_map.svh ***
// Purpose: Field positions, register numbers and reset values for the
//          status word transfer decoder.
// Assumes: 32-bit instruction words and status words.
// Notes:   Definitions only.
`ifndef SWTD_MAP_SVH
`define SWTD_MAP_SVH

// =====================================================================
// Instruction fields
`define SWTD_COND_HI      31
`define SWTD_COND_LO      28
`define SWTD_CLASS_HI     27
`define SWTD_CLASS_LO     26
`define SWTD_IMM_BIT      25
`define SWTD_OPC_HI       24
`define SWTD_OPC_LO       21
`define SWTD_SET_BIT      20
`define SWTD_RN_HI        19
`define SWTD_RN_LO        16
`define SWTD_RD_HI        15
`define SWTD_RD_LO        12
`define SWTD_SEL_BIT      22
`define SWTD_DIR_BIT      21
`define SWTD_FULL_BIT     16
`define SWTD_ROT_HI       11
`define SWTD_ROT_LO       8
`define SWTD_IMM8_HI      7
`define SWTD_IMM8_LO      0
`define SWTD_SAMT_HI      11
`define SWTD_SAMT_LO      7
`define SWTD_STYPE_HI     6
`define SWTD_STYPE_LO     5
`define SWTD_SREG_BIT     4
`define SWTD_RS_HI        11
`define SWTD_RS_LO        8
`define SWTD_RM_HI        3
`define SWTD_RM_LO        0

// =====================================================================
// Status word fields
`define SWTD_FLAG_N       31
`define SWTD_FLAG_Z       30
`define SWTD_FLAG_C       29
`define SWTD_FLAG_V       28
`define SWTD_MODE_HI      4
`define SWTD_MODE_LO      0
`define SWTD_FLAG_MASK    32'hf0000000
`define SWTD_ALL_MASK     32'hffffffff

// =====================================================================
// Register numbers and reset values
`define SWTD_PC_IDX       4'hf
`define SWTD_LINK_IDX     4'he
`define SWTD_CUR_RST      32'h000000d3
`define SWTD_SAVED_RST    32'h00000000
`define SWTD_OPC_XFER_TOP 2'h2

`endif

// *** logic/swtd_pkg.sv ***
// Purpose: Types shared by the status word transfer decoder files.
// Assumes: Constants come from swtd_map.svh.
// Notes:   Both left-shift names share one shift code.
package swtd_pkg;

  // ===================================================================
  // Shift kinds as encoded in the instruction
  typedef enum logic [1:0] {
    SH_LOGIC_LEFT   = 2'h0,
    SH_LOGIC_RIGHT  = 2'h1,
    SH_ARITH_RIGHT  = 2'h2,
    SH_ROTATE_RIGHT = 2'h3
  } swtd_shift_t;

  // The arithmetic left name is an alias, not a distinct code
  localparam swtd_shift_t SH_ARITH_LEFT_NAME = SH_LOGIC_LEFT;

  // Processor modes
  typedef enum logic [4:0] {
    MD_USER   = 5'h10,
    MD_FAST   = 5'h11,
    MD_IRQ    = 5'h12,
    MD_SUPER  = 5'h13,
    MD_ABORT  = 5'h17,
    MD_UNDEF  = 5'h1b,
    MD_SYSTEM = 5'h1f
  } swtd_mode_t;

  // Data-processing opcodes used by the decoder
  typedef enum logic [3:0] {
    OP_BIT_TEST  = 4'h8,
    OP_EQ_TEST   = 4'h9,
    OP_COMPARE   = 4'ha,
    OP_CMP_NEG   = 4'hb,
    OP_MOVE      = 4'hd,
    OP_MOVE_INV  = 4'hf
  } swtd_opc_t;

endpackage

// *** logic/swtd_shifter.sv ***
// Purpose: Barrel shifter for the register form of the second operand.
// Assumes: Combinational; caller supplies the current carry flag.
// Notes:   Amounts of 32 and above follow the extended shift results.
`timescale 1ns/1ns
module swtd_shifter
  import swtd_pkg::*;
(
  input  wire logic [31:0]       operand,
  input  wire swtd_pkg::swtd_shift_t kind,
  input  wire logic [7:0]        amount,
  input  wire logic              amount_is_imm,
  input  wire logic              carry_in,
  output logic      [31:0]       result,
  output logic                   carry_out
);

  logic [63:0] wide;
  logic [5:0]  capped;
  logic [4:0]  rot;

  // ===================================================================
  // Shift evaluation
  always_comb
  begin
    wide      = 64'h0;
    rot       = amount[4:0];
    capped    = (amount > 8'h21) ? 6'h21 : amount[5:0];
    result    = operand;
    carry_out = carry_in;
    if (amount_is_imm && amount[4:0] == 5'h0 && kind != SH_LOGIC_LEFT)
    begin
      // Zero immediate on right shifts means 32, or the extend rotate
      if (kind == SH_ROTATE_RIGHT)
      begin
        result    = {carry_in, operand[31:1]};           // [RQ14]
        carry_out = operand[0];
      end
      else
      begin
        result    = (kind == SH_ARITH_RIGHT) ? {32{operand[31]}} : 32'h0;
        carry_out = operand[31];
      end
    end
    else if (amount != 8'h0)
    begin
      case (kind)
        SH_LOGIC_LEFT:                                    // [RQ12]
        begin
          wide      = {32'h0, operand} << capped;
          result    = wide[31:0];
          carry_out = wide[32];
        end
        SH_LOGIC_RIGHT:
        begin
          wide      = {operand, 32'h0} >> capped;
          result    = wide[63:32];
          carry_out = wide[31];
        end
        SH_ARITH_RIGHT:
        begin
          // Capping at 32 keeps every larger amount as all sign bits
          wide      = $signed({operand, 32'h0}) >>> ((capped > 6'h20) ? 6'h20 : capped);
          result    = wide[63:32];
          carry_out = wide[31];
        end
        default:
        begin
          result    = (rot == 5'h0) ? operand
                      : ((operand >> rot) | (operand << (6'h20 - {1'b0, rot})));
          carry_out = result[31];
        end
      endcase
    end
  end

endmodule

// *** logic/swtd_core.sv ***
// Purpose: Decode and execute of status word transfers and of the
//          operand forms and flag effects of data-processing words.
// Assumes: Register file and ALU sit outside; operand values and ALU
//          flags for the presented word arrive in the same cycle.
// Notes:   One word per cycle; results appear one edge after instr_valid.
`timescale 1ns/1ns
`include "swtd_map.svh"

// Behaviour
// [RQ1] Status transfers execute only when the condition passes on current flags.
// [RQ2] Compare/test opcodes with the set bit clear are status transfers.
// [RQ3] Status read copies current or saved status word into a register.
// [RQ4] Status write copies a register into current or saved status word.
// [RQ5] Flag-only write takes top four bits of register or immediate.
// [RQ6] User mode may change only the flags of the current word.
// [RQ7] Saved word bank follows the mode at execution; fast mode sees its own.
// [RQ8] Software never alters the compact-instruction state bit by a write.
// [RQ9] Software never names the program counter in a status transfer.
// [RQ10] Software in user mode never touches a saved status word.
// [RQ11] Compare and test operations always set flags; the code restores from the saved word instead when destination is PC.
// [RQ12] Both left-shift names use one shift code and give one result.
// [RQ13] Immediate operand is eight bits rotated right by twice a field.
// [RQ14] Extend rotate moves right one place with carry into the top.
// [RQ15] Flag-setting write to program counter restores current from saved word.
// [RQ16] Register shift amount uses only the low byte of that register.
// [RQ17] Compare/test use first operand only; moves use destination only.
// [RQ18] Compare and test discard the result and update only flags.
// [RQ19] One select bit chooses current or saved status word.
module swtd_core
  import swtd_pkg::*;
#(
  parameter int NUM_BANKS = 5
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  input  wire logic [31:0] rm_val,
  input  wire logic [31:0] rs_val,
  input  wire logic [3:0]  alu_nzcv,
  output logic             executed_q,
  output logic             xfer_q,
  output logic             reg_wr_en_q,
  output logic [3:0]       reg_wr_idx_q,
  output logic [31:0]      reg_wr_data_q,
  output logic             use_rn_q,
  output logic             write_rd_q,
  output logic [3:0]       rn_idx_q,
  output logic [3:0]       rd_idx_q,
  output logic [31:0]      op2_q,
  output logic             shift_carry_q,
  output logic             exc_return_q,
  output logic [31:0]      cur_status_q,
  output logic [31:0]      saved_status_q
);

  // ===================================================================
  // Elaboration check
  if (NUM_BANKS != 5)
  begin : g_bad_banks
    $error("swtd_core serves exactly five saved status banks");
  end

  // ===================================================================
  // State
  logic [31:0] cur_d;
  logic [31:0] saved_q [NUM_BANKS];
  logic [31:0] saved_d [NUM_BANKS];
  logic        executed_d;
  logic        xfer_d;
  logic        reg_wr_en_d;
  logic [3:0]  reg_wr_idx_d;
  logic [31:0] reg_wr_data_d;
  logic        use_rn_d;
  logic        write_rd_d;
  logic [31:0] op2_d;
  logic        shift_carry_d;
  logic        exc_return_d;

  // ===================================================================
  // Field extraction
  logic [3:0]   cond;
  logic [3:0]   opc;
  logic         set_bit;
  logic [3:0]   rd_idx;
  logic [3:0]   rn_idx;
  logic         imm_form;
  logic         dp_word;
  logic         cmp_group;
  logic         is_xfer;
  logic         cond_ok;
  logic [4:0]   mode;
  logic         bank_ok;
  logic [2:0]   bank;
  logic [31:0]  imm_rot;
  logic [31:0]  sh_res;
  logic         sh_carry;
  logic [7:0]   sh_amt;
  logic         sh_imm;
  logic         n_f;
  logic         z_f;
  logic         c_f;
  logic         v_f;

  assign cond     = instr[`SWTD_COND_HI:`SWTD_COND_LO];
  assign opc      = instr[`SWTD_OPC_HI:`SWTD_OPC_LO];
  assign set_bit  = instr[`SWTD_SET_BIT];
  assign rd_idx   = instr[`SWTD_RD_HI:`SWTD_RD_LO];
  assign rn_idx   = instr[`SWTD_RN_HI:`SWTD_RN_LO];
  assign imm_form = instr[`SWTD_IMM_BIT];
  assign dp_word  = instr[`SWTD_CLASS_HI:`SWTD_CLASS_LO] == 2'h0;
  assign mode     = cur_status_q[`SWTD_MODE_HI:`SWTD_MODE_LO];
  assign n_f      = cur_status_q[`SWTD_FLAG_N];
  assign z_f      = cur_status_q[`SWTD_FLAG_Z];
  assign c_f      = cur_status_q[`SWTD_FLAG_C];
  assign v_f      = cur_status_q[`SWTD_FLAG_V];

  // Compare/test opcodes all sit in the 10xx opcode quarter
  assign cmp_group = dp_word && opc[3:2] == `SWTD_OPC_XFER_TOP;
  assign is_xfer   = cmp_group && !set_bit;                   // [RQ2]

  // ===================================================================
  // Condition evaluation against the current flags
  always_comb
  begin
    case (cond)
      4'h0:    cond_ok = z_f;
      4'h1:    cond_ok = !z_f;
      4'h2:    cond_ok = c_f;
      4'h3:    cond_ok = !c_f;
      4'h4:    cond_ok = n_f;
      4'h5:    cond_ok = !n_f;
      4'h6:    cond_ok = v_f;
      4'h7:    cond_ok = !v_f;
      4'h8:    cond_ok = c_f && !z_f;
      4'h9:    cond_ok = !c_f || z_f;
      4'ha:    cond_ok = n_f == v_f;
      4'hb:    cond_ok = n_f != v_f;
      4'hc:    cond_ok = !z_f && (n_f == v_f);
      4'hd:    cond_ok = z_f || (n_f != v_f);
      4'he:    cond_ok = 1'b1;
      default: cond_ok = 1'b0;
    endcase
  end

  // ===================================================================
  // Saved bank selection by the mode in force at execution
  always_comb
  begin
    bank_ok = 1'b1;
    case (mode)
      MD_FAST:  bank = 3'h0;                                   // [RQ7]
      MD_IRQ:   bank = 3'h1;
      MD_SUPER: bank = 3'h2;
      MD_ABORT: bank = 3'h3;
      MD_UNDEF: bank = 3'h4;
      default:
      begin
        // User and system modes own no saved word
        bank    = 3'h0;
        bank_ok = 1'b0;
      end
    endcase
  end

  // ===================================================================
  // Second operand: rotated immediate or shifted register
  assign imm_rot = ({24'h0, instr[`SWTD_IMM8_HI:`SWTD_IMM8_LO]}
                    >> {instr[`SWTD_ROT_HI:`SWTD_ROT_LO], 1'b0})
                 | ({24'h0, instr[`SWTD_IMM8_HI:`SWTD_IMM8_LO]}
                    << (6'h20 - {1'b0, instr[`SWTD_ROT_HI:`SWTD_ROT_LO], 1'b0})); // [RQ13]

  // Only the low byte of the shift register counts
  assign sh_imm = !instr[`SWTD_SREG_BIT];
  assign sh_amt = sh_imm ? {3'h0, instr[`SWTD_SAMT_HI:`SWTD_SAMT_LO]}
                         : rs_val[7:0];                        // [RQ16]

  swtd_shifter u_shifter (
    .operand       (rm_val),
    .kind          (swtd_shift_t'(instr[`SWTD_STYPE_HI:`SWTD_STYPE_LO])),
    .amount        (sh_amt),
    .amount_is_imm (sh_imm),
    .carry_in      (c_f),
    .result        (sh_res),
    .carry_out     (sh_carry)
  );

  // ===================================================================
  // Execute: next values of status words and result outputs
  always_comb
  begin
    logic [31:0] src;
    logic [31:0] mask;
    src           = 32'h0;
    mask          = 32'h0;
    cur_d         = cur_status_q;
    saved_d       = saved_q;
    executed_d    = 1'b0;
    xfer_d        = 1'b0;
    reg_wr_en_d   = 1'b0;
    reg_wr_idx_d  = rd_idx;
    reg_wr_data_d = reg_wr_data_q;
    use_rn_d      = 1'b0;
    write_rd_d    = 1'b0;
    op2_d         = imm_form ? imm_rot : sh_res;
    shift_carry_d = imm_form ? c_f : sh_carry;
    exc_return_d  = 1'b0;
    if (instr_valid && dp_word && cond_ok)                      // [RQ1]
    begin
      executed_d = 1'b1;
      if (is_xfer)
      begin
        xfer_d = 1'b1;
        if (!instr[`SWTD_DIR_BIT])
        begin
          // Status read into the destination register
          reg_wr_en_d   = 1'b1;                                 // [RQ3]
          reg_wr_data_d = instr[`SWTD_SEL_BIT]                  // [RQ19]
                        ? (bank_ok ? saved_q[bank] : 32'h0)
                        : cur_status_q;
        end
        else
        begin
          // Full form only from a register; flag form takes either
          if (instr[`SWTD_FULL_BIT] && !imm_form)
          begin
            src  = rm_val;                                      // [RQ4]
            mask = `SWTD_ALL_MASK;
          end
          else
          begin
            src  = imm_form ? imm_rot : rm_val;                 // [RQ5]
            mask = `SWTD_FLAG_MASK;
          end
          if (instr[`SWTD_SEL_BIT])
          begin
            if (bank_ok)
              saved_d[bank] = (saved_q[bank] & ~mask) | (src & mask); // [RQ7]
          end
          else
          begin
            // Control bits stay locked while in user mode
            if (mode == MD_USER)
              mask = mask & `SWTD_FLAG_MASK;                    // [RQ6]
            cur_d = (cur_status_q & ~mask) | (src & mask);
          end
        end
      end
      else
      begin
        // Operand usage per opcode class
        use_rn_d   = !(opc == OP_MOVE || opc == OP_MOVE_INV);   // [RQ17]
        write_rd_d = !cmp_group;                                // [RQ18]
        if (set_bit && rd_idx == `SWTD_PC_IDX)
        begin
          // Return from exception restores the word in the same step
          exc_return_d = 1'b1;                                  // [RQ15]
          if (bank_ok)
            cur_d = saved_q[bank];
        end
        else if (set_bit || cmp_group)
        begin
          cur_d[`SWTD_FLAG_N:`SWTD_FLAG_V] = alu_nzcv;          // [RQ11]
        end
      end
    end
  end

  // ===================================================================
  // Registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cur_status_q  <= `SWTD_CUR_RST;
      for (int i = 0; i < NUM_BANKS; i++)
        saved_q[i] <= `SWTD_SAVED_RST;
      executed_q    <= 1'b0;
      xfer_q        <= 1'b0;
      reg_wr_en_q   <= 1'b0;
      reg_wr_idx_q  <= 4'h0;
      reg_wr_data_q <= 32'h0;
      use_rn_q      <= 1'b0;
      write_rd_q    <= 1'b0;
      rn_idx_q      <= 4'h0;
      rd_idx_q      <= 4'h0;
      op2_q         <= 32'h0;
      shift_carry_q <= 1'b0;
      exc_return_q  <= 1'b0;
    end
    else
    begin
      cur_status_q  <= cur_d;
      saved_q       <= saved_d;
      executed_q    <= executed_d;
      xfer_q        <= xfer_d;
      reg_wr_en_q   <= reg_wr_en_d;
      reg_wr_idx_q  <= reg_wr_idx_d;
      reg_wr_data_q <= reg_wr_data_d;
      use_rn_q      <= use_rn_d;
      write_rd_q    <= write_rd_d;
      rn_idx_q      <= rn_idx;
      rd_idx_q      <= rd_idx;
      op2_q         <= op2_d;
      shift_carry_q <= shift_carry_d;
      exc_return_q  <= exc_return_d;
    end
  end

  // Saved word of the current mode, zero where the mode has none
  assign saved_status_q = bank_ok ? saved_q[bank] : 32'h0;

endmodule

// *** sim/swtd_chk.sv ***
// Purpose: Port-level assertions for the status word transfer decoder.
// Assumes: One clock, synchronous active-low reset, one-cycle answer.
// Notes:   Antecedents built on go_s use the always-true condition so flags never gate them.
`timescale 1ns/1ns
module swtd_chk
  import swtd_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        instr_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] rm_val,
  input wire logic [3:0]  alu_nzcv,
  input wire logic        executed_q,
  input wire logic        xfer_q,
  input wire logic        reg_wr_en_q,
  input wire logic [31:0] reg_wr_data_q,
  input wire logic        use_rn_q,
  input wire logic        write_rd_q,
  input wire logic [31:0] op2_q,
  input wire logic        shift_carry_q,
  input wire logic        exc_return_q,
  input wire logic [31:0] cur_status_q,
  input wire logic [31:0] saved_status_q
);
  import swtd_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ==================================================================
  // Word shapes taken with condition always and data class
  sequence go_s; instr_valid && instr[31:26] == 6'h38; endsequence
  sequence cmp_s; go_s ##0 instr[24:23] == 2'h2 && instr[20] && instr[15:12] != 4'hf; endsequence
  sequence fw_s; go_s ##0 instr[24:20] == 5'h12 && (instr[25] || !instr[16]); endsequence
  sequence rd_s; go_s ##0 instr[24:20] == 5'h10; endsequence
  sequence rrx_s; go_s ##0 !instr[25] && instr[11:4] == 8'h06; endsequence
  sequence ret_s; go_s ##0 instr[20] && instr[15:12] == 4'hf; endsequence

  // Rotated immediate, doubled rotate field
  function automatic logic [31:0] rimm(logic [31:0] w);
    logic [63:0] t;
    t = {24'h0, w[7:0], 24'h0, w[7:0]} >> (2 * w[11:8]);
    return t[31:0];
  endfunction

  // ==================================================================
  // Assertions
  no_word_a: assert property (!instr_valid |=> !executed_q && !xfer_q)
    else $error("pulse without a word");
  never_cond_a: assert property (instr_valid && instr[31:28] == 4'hf |=> !executed_q)
    else $error("never condition executed");
  xfer_set_a: assert property (instr_valid && instr[20] |=> !xfer_q)
    else $error("transfer decoded with set bit");
  read_cur_a: assert property (rd_s |=> reg_wr_en_q && reg_wr_data_q == $past(cur_status_q))
    else $error("status read lost current word");
  flag_only_a: assert property (fw_s |=> cur_status_q[27:0] == $past(cur_status_q[27:0]))
    else $error("flag write touched control bits");
  user_ctrl_a: assert property (cur_status_q[4:0] == MD_USER
    && !(instr_valid && instr[20] && instr[15:12] == 4'hf)
    |=> cur_status_q[27:0] == $past(cur_status_q[27:0]))
    else $error("user mode changed control bits");
  no_bank_a: assert property (cur_status_q[4:0] == MD_USER
    || cur_status_q[4:0] == MD_SYSTEM
    |-> saved_status_q == 32'h0)
    else $error("saved word visible without bank");
  cmp_flag_a: assert property (cmp_s |=> executed_q
    && use_rn_q && !write_rd_q
    && cur_status_q[31:28] == $past(alu_nzcv))
    else $error("compare group flag effect wrong");
  imm_rot_a: assert property (instr_valid && instr[25] |=> op2_q == rimm($past(instr)))
    else $error("immediate rotate wrong");
  rrx_a: assert property (rrx_s |=> op2_q
    == {$past(cur_status_q[29]), $past(rm_val[31:1])}
    && shift_carry_q == $past(rm_val[0]))
    else $error("extend rotate wrong");
  exc_ret_a: assert property (ret_s |=> exc_return_q && cur_status_q == $past(saved_status_q))
    else $error("exception return did not restore");
endmodule

bind swtd_core swtd_chk chk (.ref_clk, .rst_b, .instr_valid, .instr, .rm_val, .alu_nzcv,
  .executed_q, .xfer_q, .reg_wr_en_q, .reg_wr_data_q, .use_rn_q, .write_rd_q, .op2_q,
  .shift_carry_q, .exc_return_q, .cur_status_q, .saved_status_q);

// *** sim/swtd_tb.sv ***
// Purpose: Self-checking bench with a behavioural model of the decoder.
// Assumes: Inputs change on the falling edge; results read just after rise.
// Notes:   Software duties (no compact-state change, no PC operand) kept by stimulus.
`timescale 1ns/1ns
module tb;
  import swtd_pkg::*;
  logic        ref_clk, rst_b, instr_valid, executed_q, xfer_q, reg_wr_en_q;
  logic        use_rn_q, write_rd_q, shift_carry_q, exc_return_q;
  logic [31:0] instr, rm_val, rs_val, reg_wr_data_q, op2_q, cur_status_q, saved_status_q;
  logic [3:0]  alu_nzcv, reg_wr_idx_q, rn_idx_q, rd_idx_q;
  logic [31:0] m_cur, w, rs_next;
  logic [31:0] m_bank [5];
  int          fail_count, total_checks, cycles;
  // Directed words with their register value; T bit stays clear
  logic [63:0] dseq [16] = '{64'he10f1000_00000000, 64'he129f000_200000d2,
    64'he169f000_600000d3, 64'he14f2000_00000000, 64'he368f20f_00000000, 64'he129f000_000000d1,
    64'he14f3000_00000000, 64'he169f000_12345011, 64'he14f3000_00000000, 64'he129f000_000000d2,
    64'he1a01060_a5a5a5a5, 64'he1a01312_0000f00f, 64'he1a01372_80000001, 64'he1b0f00e_00000000,
    64'he129f000_00000010, 64'he129f000_a00000d3};

  swtd_core #(.NUM_BANKS(5)) uut (.ref_clk, .rst_b, .instr_valid, .instr, .rm_val, .rs_val,
    .alu_nzcv, .executed_q, .xfer_q, .reg_wr_en_q, .reg_wr_idx_q, .reg_wr_data_q, .use_rn_q,
    .write_rd_q, .rn_idx_q, .rd_idx_q, .op2_q, .shift_carry_q, .exc_return_q,
    .cur_status_q, .saved_status_q);

  // ==================================================================
  // Clock and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      conclude();
    end
  end

  // ==================================================================
  // Model helpers
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Condition test against N,Z,C,V
  function automatic logic pass(logic [3:0] c, logic [3:0] f);
    logic b;
    case (c[3:1])
      3'h0: b = f[2];
      3'h1: b = f[1];
      3'h2: b = f[3];
      3'h3: b = f[0];
      3'h4: b = f[1] & ~f[2];
      3'h5: b = f[3] == f[0];
      3'h6: b = ~f[2] & (f[3] == f[0]);
      default: b = 1'b1;
    endcase
    return (c[3:1] == 3'h7) ? ~c[0] : b ^ c[0];
  endfunction
  // Bank slot for a mode, negative when the mode has none
  function automatic int bidx(logic [4:0] m);
    case (m)
      MD_FAST: return 0;
      MD_IRQ: return 1;
      MD_SUPER: return 2;
      MD_ABORT: return 3;
      MD_UNDEF: return 4;
      default: return -1;
    endcase
  endfunction
  // Shifter as {carry, result}; 64-bit windows give the extended cases
  function automatic logic [32:0] shf(logic [31:0] v, logic [1:0] k, int a, logic c, logic im);
    logic [63:0] t;
    if (a == 0 && (!im || k == 2'h0))
      return {c, v};
    if (a == 0 && k == 2'h3)
      return {v[0], c, v[31:1]};
    if (a == 0)
      a = 32;
    case (k)
      2'h0: t = {32'h0, v} << a;
      2'h1: t = {v, 32'h0} >> a;
      2'h2: t = $signed({v, 32'h0}) >>> (a > 63 ? 63 : a);
      default: t = {v, v} >> (a % 32 == 0 ? 32 : a % 32);
    endcase
    return (k == 2'h0) ? {t[32], t[31:0]} : (k == 2'h3) ? {t[31], t[31:0]} : {t[31], t[63:32]};
  endfunction

  // One word per cycle; model updates, then outputs are compared, the register write index and data only on status reads
  task automatic step(input logic [31:0] iw, input logic [31:0] rm, input logic [3:0] nz);
    logic [63:0] t;
    logic [32:0] sh;
    logic [31:0] mk, re, v;
    logic        ex, xf, rdop, ret;
    int          b;
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr = iw;
    rm_val = rm;
    alu_nzcv = nz;
    rs_val = rs_next;
    t = {24'h0, iw[7:0], 24'h0, iw[7:0]} >> (2 * iw[11:8]);
    sh = iw[25] ? {m_cur[29], t[31:0]} :
      shf(rm, iw[6:5], iw[4] ? int'(rs_val[7:0]) : int'(iw[11:7]), m_cur[29], !iw[4]);
    ex = iw[27:26] == 2'h0 && pass(iw[31:28], m_cur[31:28]);
    xf = ex && iw[24:23] == 2'h2 && !iw[20];
    rdop = xf && !iw[21];
    ret = ex && iw[20] && iw[15:12] == 4'hf;
    b = bidx(m_cur[4:0]);
    re = iw[22] ? (b < 0 ? 32'h0 : m_bank[b]) : m_cur;
    v = iw[25] ? sh[31:0] : rm;
    mk = (!iw[25] && iw[16] && (iw[22] || m_cur[4:0] != MD_USER)) ? '1 : 32'hf0000000;
    // Return restores from the bank of the mode, whatever the select bit; a mode with no bank keeps the word
    if (ret)
      m_cur = (b < 0) ? m_cur : m_bank[b];
    else if (ex && iw[20])
      m_cur[31:28] = nz;
    else if (xf && iw[21] && !iw[22])
      m_cur = (m_cur & ~mk) | (v & mk);
    else if (xf && iw[21] && b >= 0)
      m_bank[b] = (m_bank[b] & ~mk) | (v & mk);
    b = bidx(m_cur[4:0]);
    @(posedge ref_clk);
    #1;
    chk({executed_q, exc_return_q}, {ex, ret});
    chk({xfer_q, reg_wr_en_q}, {xf, rdop});
    if (rdop)
      chk({reg_wr_idx_q, reg_wr_data_q}, {iw[15:12], re});
    chk({use_rn_q, write_rd_q, rn_idx_q, rd_idx_q}, {ex && !xf && !(iw[24:23] == 2'h3 && iw[21]),
      ex && !xf && iw[24:23] != 2'h2, iw[19:16], iw[15:12]});
    chk({shift_carry_q, op2_q}, sh);
    chk(cur_status_q, m_cur);
    chk(saved_status_q, b < 0 ? 32'h0 : m_bank[b]);
  endtask

  // ==================================================================
  // Main sequence
  initial
  begin
    {rst_b, instr_valid, instr, rm_val, alu_nzcv} = '0;
    rs_val = 32'hffffff04;
    rs_next = 32'hffffff04;
    m_cur = 32'h000000d3;
    m_bank = '{default: 32'h0};
    void'($urandom(32'hbb0b8385));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    // Banked reads and writes, shifts, exception return, then user mode
    foreach (dseq[i])
      step(dseq[i][63:32], dseq[i][31:0], 4'($urandom));
    // Compare group with random flags in user mode
    for (int op = 8; op < 12; op++)
      step(32'he0100000 | (op << 21) | ($urandom & 32'h000f7f6f), $urandom, 4'($urandom));
    // Every condition code on a flag-only write
    for (int c = 0; c < 16; c++)
      step({4'(c), 28'h328f000} | ($urandom & 32'hfff), 0, 4'h0);
    // Random words in user mode; compare group sets flags, no PC target when the set bit is on
    repeat (400)
    begin
      w = $urandom;
      w[27:26] = ($urandom % 8 == 0) ? 2'h1 : 2'h0;
      if (w[24:23] == 2'h2)
        w[20] = 1'b1;
      if (w[20])
        w[15] = 1'b0;
      if (!w[25] && w[4])
        w[7] = 1'b0;
      rs_next = $urandom;
      step(w, $urandom, 4'($urandom));
    end
    @(negedge ref_clk);
    instr_valid = 1'b0;
    repeat (2) @(posedge ref_clk);
    conclude();
  end
endmodule
